// ---- rtl/ais_top.sv ----
// Analog input scaler: channel capture, routing, scaling and APB registers.
//
// Function
// - Config bit clear reads channel as volts, set reads it as milliamps.
// - Input low point gives output low point; input high gives output high.
// - Output low may exceed output high, giving an inverted mapping.
// - Default speed mapping is 0 V to 0 Hz and 10 V to 60 Hz.
// - Current setup uses the same input points as volts, 0 mA and 10 mA after reset.
// - Input high point may be lowered so a small source spans full output.
// - Trim gives minus ten percent at low point, plus ten at high point.
// - Output points are fixed except for speed reference, trim and the two command views.
// - Command values are shown as frequency between minimum speed and maximum.
// - Torque reference maps 0 V to 0 percent and 10 V to 200 percent.
// - Current limit source selector routes a channel to the current limit.
// - DC hold source selector routes a channel to the hold level.
// - Loop setpoint and feedback take independently selected channels.
module ais_top (
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              ch1_valid_in,
  input  wire ais_pkg::ais_val_t ch1_volt_in,
  input  wire ais_pkg::ais_val_t ch1_curr_in,
  input  wire logic              ch2_valid_in,
  input  wire ais_pkg::ais_val_t ch2_volt_in,
  input  wire ais_pkg::ais_val_t ch2_curr_in,
  output ais_pkg::ais_val_t      speed_ref_out,
  output ais_pkg::ais_val_t      trim_ref_out,
  output ais_pkg::ais_val_t      torque_ref_out,
  output ais_pkg::ais_val_t      current_limit_out,
  output ais_pkg::ais_val_t      dc_hold_level_out,
  output ais_pkg::ais_val_t      loop_setpoint_out,
  output ais_pkg::ais_val_t      loop_feedback_out
);
  import ais_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [CFG_W-1:0] cfg_ff;
  logic [CFG_W-1:0] nxt_cfg;
  logic [SEL_W-1:0] sel_ff;
  logic [SEL_W-1:0] nxt_sel;
  ais_val_t         input_scale_low_point_ff [NCH];
  ais_val_t         nxt_input_scale_low_point [NCH];
  ais_val_t         input_scale_high_point_ff [NCH];
  ais_val_t         nxt_input_scale_high_point [NCH];
  ais_val_t         primary_ref_output_low_ff;
  ais_val_t         nxt_primary_ref_output_low;
  ais_val_t         primary_ref_output_high_ff;
  ais_val_t         nxt_primary_ref_output_high;
  ais_val_t         trim_output_low_ff;
  ais_val_t         nxt_trim_output_low;
  ais_val_t         trim_output_high_ff;
  ais_val_t         nxt_trim_output_high;
  ais_val_t         min_speed_ff;
  ais_val_t         nxt_min_speed;
  ais_val_t         max_freq_ff;
  ais_val_t         nxt_max_freq;
  ais_val_t         spd_ff;
  ais_val_t         nxt_spd;
  logic [31:0]      rdata_ff;
  logic [31:0]      nxt_rdata;
  logic [31:0]      rd_word;
  logic             hit;
  logic             wr_en;
  ais_val_t         reading [NCH];
  ais_val_t         sx [NDEST];
  ais_val_t         slo [NDEST];
  ais_val_t         shi [NDEST];
  ais_val_t         solo [NDEST];
  ais_val_t         sohi [NDEST];
  ais_val_t         dy [NDEST];

  // ----------------------------------------
  // Channel capture
  // ----------------------------------------
  ais_chan_capture u_cap1 (
    .clock_in        (clock_in),
    .reset_in        (reset_in),
    .current_mode_in (cfg_ff[0]),
    .valid_in        (ch1_valid_in),
    .volt_in         (ch1_volt_in),
    .curr_in         (ch1_curr_in),
    .reading_out     (reading[0])
  );

  ais_chan_capture u_cap2 (
    .clock_in        (clock_in),
    .reset_in        (reset_in),
    .current_mode_in (cfg_ff[1]),
    .valid_in        (ch2_valid_in),
    .volt_in         (ch2_volt_in),
    .curr_in         (ch2_curr_in),
    .reading_out     (reading[1])
  );

  // ----------------------------------------
  // Routing of channels to destinations
  // ----------------------------------------
  // An unrouted destination gets a zero output span, so it settles at zero.
  always_comb begin
    ais_src_t src;
    logic     c;
    src = AIS_SRC_NONE;
    c   = 1'b0;
    for (int d = 0; d < NDEST; d++) begin
      if (d < NSEL) begin
        src = ais_src_t'(sel_ff[2*d +: 2]);
      end else begin
        src = (d == D_VIEW1) ? AIS_SRC_CH1 : AIS_SRC_CH2;
      end
      c       = (src == AIS_SRC_CH2);
      sx[d]   = reading[c];
      slo[d]  = input_scale_low_point_ff[c];
      shi[d]  = input_scale_high_point_ff[c];
      solo[d] = FIX_OUT_LO[d];
      sohi[d] = FIX_OUT_HI[d];
      if (d == D_SPEED) begin
        solo[d] = primary_ref_output_low_ff;
        sohi[d] = primary_ref_output_high_ff;
      end
      if (d == D_TRIM) begin
        solo[d] = trim_output_low_ff;
        sohi[d] = trim_output_high_ff;
      end
      if (d >= D_VIEW1) begin
        solo[d] = min_speed_ff;
        sohi[d] = max_freq_ff;
      end
      if (src == AIS_SRC_NONE || src == AIS_SRC_RSVD) begin
        solo[d] = RST_ZERO;
        sohi[d] = RST_ZERO;
      end
    end
  end

  // ----------------------------------------
  // Scaling paths
  // ----------------------------------------
  for (genvar g = 0; g < NDEST; g++) begin : g_scale
    ais_scale_if sif ();
    assign sif.x      = sx[g];
    assign sif.in_lo  = slo[g];
    assign sif.in_hi  = shi[g];
    assign sif.out_lo = solo[g];
    assign sif.out_hi = sohi[g];
    assign dy[g]      = sif.y;
    ais_scaler u_scl (
      .clock_in (clock_in),
      .reset_in (reset_in),
      .sif      (sif.scl)
    );
  end

  // ----------------------------------------
  // Trimmed speed reference
  // ----------------------------------------
  // The trim lands one clock after the scaled values it combines.
  always_comb begin
    logic signed [31:0] base;
    logic signed [31:0] adj;
    logic signed [31:0] sum;
    base = 32'(dy[D_SPEED]);
    adj  = (base * 32'(dy[D_TRIM])) / TRIM_DEN;
    sum  = base + adj;
    if (sum > 32'(max_freq_ff)) begin
      sum = 32'(max_freq_ff);
    end
    if (sum < 32'(min_speed_ff)) begin
      sum = 32'(min_speed_ff);
    end
    nxt_spd = 16'(sum);
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign wr_en = psel_in & penable_in & pwrite_in;

  always_comb begin
    nxt_cfg                     = cfg_ff;
    nxt_sel                     = sel_ff;
    nxt_input_scale_low_point   = input_scale_low_point_ff;
    nxt_input_scale_high_point  = input_scale_high_point_ff;
    nxt_primary_ref_output_low  = primary_ref_output_low_ff;
    nxt_primary_ref_output_high = primary_ref_output_high_ff;
    nxt_trim_output_low         = trim_output_low_ff;
    nxt_trim_output_high        = trim_output_high_ff;
    nxt_min_speed               = min_speed_ff;
    nxt_max_freq                = max_freq_ff;
    if (wr_en) begin
      case (paddr_in)
        A_CFG:     nxt_cfg = pwdata_in[CFG_W-1:0];
        A_IN1_LO:  nxt_input_scale_low_point[0] = pwdata_in[15:0];
        A_IN1_HI:  nxt_input_scale_high_point[0] = pwdata_in[15:0];
        A_IN2_LO:  nxt_input_scale_low_point[1] = pwdata_in[15:0];
        A_IN2_HI:  nxt_input_scale_high_point[1] = pwdata_in[15:0];
        A_SPD_LO:  nxt_primary_ref_output_low = pwdata_in[15:0];
        A_SPD_HI:  nxt_primary_ref_output_high = pwdata_in[15:0];
        A_TRIM_LO: nxt_trim_output_low = pwdata_in[15:0];
        A_TRIM_HI: nxt_trim_output_high = pwdata_in[15:0];
        A_SEL:     nxt_sel = pwdata_in[SEL_W-1:0];
        A_MIN_SPD: nxt_min_speed = pwdata_in[15:0];
        A_MAX_FRQ: nxt_max_freq = pwdata_in[15:0];
        default:   nxt_cfg = cfg_ff;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads and decode
  // ----------------------------------------
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr_in)
      A_CFG:     rd_word = {30'h0000_0000, cfg_ff};
      A_IN1_LO:  rd_word = {16'h0000, input_scale_low_point_ff[0]};
      A_IN1_HI:  rd_word = {16'h0000, input_scale_high_point_ff[0]};
      A_IN2_LO:  rd_word = {16'h0000, input_scale_low_point_ff[1]};
      A_IN2_HI:  rd_word = {16'h0000, input_scale_high_point_ff[1]};
      A_SPD_LO:  rd_word = {16'h0000, primary_ref_output_low_ff};
      A_SPD_HI:  rd_word = {16'h0000, primary_ref_output_high_ff};
      A_TRIM_LO: rd_word = {16'h0000, trim_output_low_ff};
      A_TRIM_HI: rd_word = {16'h0000, trim_output_high_ff};
      A_SEL:     rd_word = {18'h0_0000, sel_ff};
      A_MIN_SPD: rd_word = {16'h0000, min_speed_ff};
      A_MAX_FRQ: rd_word = {16'h0000, max_freq_ff};
      A_SPEED:   rd_word = {16'h0000, spd_ff};
      A_TRIM:    rd_word = {16'h0000, dy[1]};
      A_TORQ:    rd_word = {16'h0000, dy[2]};
      A_CLIM:    rd_word = {16'h0000, dy[3]};
      A_DCH:     rd_word = {16'h0000, dy[4]};
      A_SETP:    rd_word = {16'h0000, dy[5]};
      A_FDBK:    rd_word = {16'h0000, dy[6]};
      A_VIEW1:   rd_word = {16'h0000, dy[7]};
      A_VIEW2:   rd_word = {16'h0000, dy[8]};
      A_RAW1:    rd_word = {16'h0000, reading[0]};
      A_RAW2:    rd_word = {16'h0000, reading[1]};
      default:   hit = 1'b0;
    endcase
  end

  // Read data is caught in the setup cycle so it leaves a flip-flop.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (psel_in & ~penable_in) begin
      nxt_rdata = rd_word;
    end
  end

  assign pready_out  = psel_in & penable_in;
  assign pslverr_out = psel_in & penable_in & ~hit;
  assign prdata_out  = rdata_ff;

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cfg_ff                     <= '0;
      sel_ff                     <= '0;
      input_scale_low_point_ff   <= '{default: RST_ZERO};
      input_scale_high_point_ff  <= '{default: RST_IN_HI};
      primary_ref_output_low_ff  <= RST_ZERO;
      primary_ref_output_high_ff <= RST_SPD_HI;
      trim_output_low_ff         <= RST_TRIM_LO;
      trim_output_high_ff        <= RST_TRIM_HI;
      min_speed_ff               <= RST_ZERO;
      max_freq_ff                <= RST_MAX_FRQ;
      spd_ff                     <= RST_ZERO;
      rdata_ff                   <= 32'h0000_0000;
    end else begin
      cfg_ff                     <= nxt_cfg;
      sel_ff                     <= nxt_sel;
      input_scale_low_point_ff   <= nxt_input_scale_low_point;
      input_scale_high_point_ff  <= nxt_input_scale_high_point;
      primary_ref_output_low_ff  <= nxt_primary_ref_output_low;
      primary_ref_output_high_ff <= nxt_primary_ref_output_high;
      trim_output_low_ff         <= nxt_trim_output_low;
      trim_output_high_ff        <= nxt_trim_output_high;
      min_speed_ff               <= nxt_min_speed;
      max_freq_ff                <= nxt_max_freq;
      spd_ff                     <= nxt_spd;
      rdata_ff                   <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Destination outputs
  // ----------------------------------------
  assign speed_ref_out     = spd_ff;
  assign trim_ref_out      = dy[D_TRIM];
  assign torque_ref_out    = dy[D_TORQ];
  assign current_limit_out = dy[D_CLIM];
  assign dc_hold_level_out = dy[D_DCH];
  assign loop_setpoint_out = dy[D_SETP];
  assign loop_feedback_out = dy[D_FDBK];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  chk_reset_defaults:
  assert property ($fell(reset_in) |-> primary_ref_output_low_ff == RST_ZERO
                   && primary_ref_output_high_ff == RST_SPD_HI && input_scale_high_point_ff[0] == RST_IN_HI)
    else $error("Speed mapping defaults are wrong after reset.");

  chk_offset_low:
  assert property (cfg_ff[0] && sel_ff[1:0] == 2'h1 && reading[0] == input_scale_low_point_ff[0]
                   && input_scale_high_point_ff[0] > input_scale_low_point_ff[0]
                   |=> speed_ref_out == $past(primary_ref_output_low_ff) || $past(primary_ref_output_low_ff) < min_speed_ff
                       || $past(primary_ref_output_low_ff) > max_freq_ff
                       || $past(dy[D_TRIM]) != RST_ZERO || $changed(dy[D_SPEED]))
    else $error("Current low point did not give the low speed.");

  chk_trim_span:
  assert property (sel_ff[3:2] != 2'h0 && sel_ff[3:2] != 2'h3 && trim_output_low_ff <= trim_output_high_ff
                   |=> trim_ref_out >= $past(trim_output_low_ff) && trim_ref_out <= $past(trim_output_high_ff))
    else $error("Trim left its span.");

  chk_view_window:
  assert property (min_speed_ff <= max_freq_ff |=> dy[D_VIEW1] >= $past(min_speed_ff)
                   && dy[D_VIEW1] <= $past(max_freq_ff))
    else $error("Command view left the speed window.");

  chk_torque_full:
  assert property (sel_ff[5:4] == 2'h1 && reading[0] >= input_scale_high_point_ff[0]
                   && input_scale_high_point_ff[0] > input_scale_low_point_ff[0]
                   |=> torque_ref_out == FIX_OUT_HI[D_TORQ])
    else $error("Torque did not reach full scale at the high point.");

  chk_clim_off:
  assert property (sel_ff[7:6] == 2'h0 |=> current_limit_out == RST_ZERO)
    else $error("Unrouted current limit is not zero.");

  chk_hold_low:
  assert property (sel_ff[9:8] == 2'h1 && reading[0] <= input_scale_low_point_ff[0]
                   && input_scale_high_point_ff[0] > input_scale_low_point_ff[0]
                   |=> dc_hold_level_out == FIX_OUT_LO[D_DCH])
    else $error("Hold level did not follow its channel.");

  chk_loop_pair:
  assert property (sel_ff[11:10] == sel_ff[13:12] |=> loop_setpoint_out == loop_feedback_out)
    else $error("Setpoint and feedback differ on one source.");

  chk_trim_lag:
  assert property ($stable(dy[D_SPEED]) && $stable(dy[D_TRIM]) && $stable(min_speed_ff)
                   && $stable(max_freq_ff) |=> $stable(speed_ref_out))
    else $error("Speed output moved with settled operands.");
endmodule

// ---- include/ais_pkg.sv ----
// Constants and types shared by the analog input scaler.
package ais_pkg;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic signed [15:0] ais_val_t;
  typedef enum logic [1:0] {AIS_SRC_NONE, AIS_SRC_CH1, AIS_SRC_CH2, AIS_SRC_RSVD} ais_src_t;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CFG     = 8'h00;
  localparam logic [7:0] A_IN1_LO  = 8'h04;
  localparam logic [7:0] A_IN1_HI  = 8'h08;
  localparam logic [7:0] A_IN2_LO  = 8'h0c;
  localparam logic [7:0] A_IN2_HI  = 8'h10;
  localparam logic [7:0] A_SPD_LO  = 8'h14;
  localparam logic [7:0] A_SPD_HI  = 8'h18;
  localparam logic [7:0] A_TRIM_LO = 8'h1c;
  localparam logic [7:0] A_TRIM_HI = 8'h20;
  localparam logic [7:0] A_SEL     = 8'h24;
  localparam logic [7:0] A_MIN_SPD = 8'h28;
  localparam logic [7:0] A_MAX_FRQ = 8'h2c;
  localparam logic [7:0] A_SPEED   = 8'h30;
  localparam logic [7:0] A_TRIM    = 8'h34;
  localparam logic [7:0] A_TORQ    = 8'h38;
  localparam logic [7:0] A_CLIM    = 8'h3c;
  localparam logic [7:0] A_DCH     = 8'h40;
  localparam logic [7:0] A_SETP    = 8'h44;
  localparam logic [7:0] A_FDBK    = 8'h48;
  localparam logic [7:0] A_VIEW1   = 8'h4c;
  localparam logic [7:0] A_VIEW2   = 8'h50;
  localparam logic [7:0] A_RAW1    = 8'h54;
  localparam logic [7:0] A_RAW2    = 8'h58;
  // ----------------------------------------
  // Destinations and field positions
  // ----------------------------------------
  localparam int NCH     = 2;
  localparam int NSEL    = 7;
  localparam int NDEST   = 9;
  localparam int D_SPEED = 0;
  localparam int D_TRIM  = 1;
  localparam int D_TORQ  = 2;
  localparam int D_CLIM  = 3;
  localparam int D_DCH   = 4;
  localparam int D_SETP  = 5;
  localparam int D_FDBK  = 6;
  localparam int D_VIEW1 = 7;
  localparam int CFG_W   = 2;
  localparam int SEL_W   = 2 * NSEL;
  // ----------------------------------------
  // Values after reset (mV, uA, 0.01 Hz, 0.01 %)
  // ----------------------------------------
  localparam ais_val_t RST_ZERO    = 16'sh0000;
  localparam ais_val_t RST_IN_HI   = 16'sh2710;
  localparam ais_val_t RST_SPD_HI  = 16'sh1770;
  localparam ais_val_t RST_TRIM_LO = -16'sh03e8;
  localparam ais_val_t RST_TRIM_HI = 16'sh03e8;
  localparam ais_val_t RST_MAX_FRQ = 16'sh1770;
  localparam logic signed [31:0] TRIM_DEN = 32'sh00002710;
  localparam ais_val_t FIX_OUT_LO [NDEST] = '{default: 16'sh0000};
  localparam ais_val_t FIX_OUT_HI [NDEST] = '{16'sh0000, 16'sh0000, 16'sh4e20, 16'sh2710,
                                             16'sh2710, 16'sh2710, 16'sh2710, 16'sh0000, 16'sh0000};
endpackage

// ---- include/ais_scale_if.sv ----
// Operands and result of one scaling path.
interface ais_scale_if;
  import ais_pkg::*;
  ais_val_t x;
  ais_val_t in_lo;
  ais_val_t in_hi;
  ais_val_t out_lo;
  ais_val_t out_hi;
  ais_val_t y;
  modport drv (output x, in_lo, in_hi, out_lo, out_hi, input y);
  modport scl (input x, in_lo, in_hi, out_lo, out_hi, output y);
endinterface

// ---- rtl/ais_chan_capture.sv ----
// Sample register of one analog channel with unit selection.
module ais_chan_capture (
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  input  wire logic              current_mode_in,
  input  wire logic              valid_in,
  input  wire ais_pkg::ais_val_t volt_in,
  input  wire ais_pkg::ais_val_t curr_in,
  output ais_pkg::ais_val_t      reading_out
);
  import ais_pkg::*;
  ais_val_t reading_ff;
  ais_val_t nxt_reading;

  always_comb begin
    nxt_reading = reading_ff;
    if (valid_in) begin
      nxt_reading = current_mode_in ? curr_in : volt_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      reading_ff <= RST_ZERO;
    end else begin
      reading_ff <= nxt_reading;
    end
  end

  assign reading_out = reading_ff;

  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  chk_unit_select:
  assert property (valid_in && current_mode_in |=> reading_ff == $past(curr_in))
    else $error("Current mode did not take the current reading.");
  chk_sample_hold:
  assert property (!valid_in |=> $stable(reading_ff))
    else $error("Reading changed without a sample.");
endmodule

// ---- rtl/ais_scaler.sv ----
// Clamped linear scaler with one registered result per clock.
module ais_scaler (
  input wire logic clock_in,
  input wire logic reset_in,
  ais_scale_if.scl sif
);
  import ais_pkg::*;
  ais_val_t y_ff;
  ais_val_t nxt_y;

  // ----------------------------------------
  // Interpolation
  // ----------------------------------------
  // A zero input span has no slope, so it simply yields the low output point.
  always_comb begin
    logic signed [39:0] den;
    logic signed [39:0] num;
    logic signed [39:0] q;
    logic               rise;
    den  = 40'(sif.in_hi) - 40'(sif.in_lo);
    num  = (40'(sif.x) - 40'(sif.in_lo)) * (40'(sif.out_hi) - 40'(sif.out_lo));
    rise = den > 40'sh0;
    q    = 40'sh0;
    if (den == 40'sh0) begin
      nxt_y = sif.out_lo;
    end else if (rise ? sif.x <= sif.in_lo : sif.x >= sif.in_lo) begin
      nxt_y = sif.out_lo;
    end else if (rise ? sif.x >= sif.in_hi : sif.x <= sif.in_hi) begin
      nxt_y = sif.out_hi;
    end else begin
      q     = num / den;
      nxt_y = sif.out_lo + 16'(q);
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      y_ff <= RST_ZERO;
    end else begin
      y_ff <= nxt_y;
    end
  end

  assign sif.y = y_ff;

  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_rising;
    sif.in_hi > sif.in_lo;
  endsequence
  sequence s_quiet;
    $stable(sif.x) && $stable(sif.in_lo) && $stable(sif.in_hi) && $stable(sif.out_lo) && $stable(sif.out_hi);
  endsequence

  chk_low_point:
  assert property (s_rising and sif.x == sif.in_lo |=> sif.y == $past(sif.out_lo))
    else $error("Low input point did not give low output point.");
  chk_high_point:
  assert property (s_rising and sif.x == sif.in_hi |=> sif.y == $past(sif.out_hi))
    else $error("High input point did not give high output point.");
  chk_invert_span:
  assert property (s_rising and (sif.out_lo > sif.out_hi && sif.x > sif.in_lo && sif.x < sif.in_hi)
                   |=> sif.y <= $past(sif.out_lo) && sif.y >= $past(sif.out_hi))
    else $error("Inverted mapping left its output span.");
  chk_clamp_high:
  assert property (s_rising and sif.x > sif.in_hi |=> sif.y == $past(sif.out_hi))
    else $error("Reading above the high point was not clamped.");
  chk_settle_next:
  assert property (s_quiet |=> $stable(sif.y))
    else $error("Result moved while its operands stood still.");
endmodule

// ---- tb/ais_sensor.sv ----
// Behavioural analog transmitter that hands one sample to the converter on request.
module ais_sensor (
  input  wire logic              clock_in,
  input  wire logic              go_in,
  input  wire ais_pkg::ais_val_t v_in,
  input  wire ais_pkg::ais_val_t c_in,
  output logic                   valid_out,
  output ais_pkg::ais_val_t      volt_out,
  output ais_pkg::ais_val_t      curr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {valid_out, volt_out, curr_out} = '0;
  // Between samples the lines churn, so a reading taken at the wrong edge shows up as garbage.
  always @(posedge clock_in) begin
    valid_out <= go_in;
    volt_out  <= go_in ? v_in : ~volt_out;
    curr_out  <= go_in ? c_in : ~curr_out;
  end
endmodule

// ---- tb/analog_input_scaler_bench.sv ----
// Self-checking bench for the analog input scaler.
module analog_input_scaler_bench import ais_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in = 0, reset_in = 1, psel = 0, pen = 0, pwr = 0, g = 0, v1, v2, pready, pslverr, er;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] lf = 16'haefc;
  ais_val_t    a1 = '0, b1 = '0, a2 = '0, b2 = '0, c1v, c1c, c2v, c2c;
  ais_val_t    o [7];
  int          n_errors = 0, cmp_count = 0, cyc = 0, x, y;
  ais_top u_dut (.clock_in(clock_in), .reset_in(reset_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .ch1_valid_in(v1), .ch1_volt_in(c1v), .ch1_curr_in(c1c), .ch2_valid_in(v2),
    .ch2_volt_in(c2v), .ch2_curr_in(c2c), .speed_ref_out(o[0]), .trim_ref_out(o[1]),
    .torque_ref_out(o[2]), .current_limit_out(o[3]), .dc_hold_level_out(o[4]),
    .loop_setpoint_out(o[5]), .loop_feedback_out(o[6]));
  ais_sensor u_s1 (.clock_in(clock_in), .go_in(g), .v_in(a1), .c_in(b1), .valid_out(v1),
    .volt_out(c1v), .curr_out(c1c));
  ais_sensor u_s2 (.clock_in(clock_in), .go_in(g), .v_in(a2), .c_in(b2), .valid_out(v2),
    .volt_out(c2v), .curr_out(c2c));
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected scaler result: clamped at both points, division truncates toward zero.
  function automatic int scl(int x, int lo, int hi, int ol, int oh);
    if (hi == lo || x <= lo) return ol;
    if (x >= hi) return oh;
    return ol + (x - lo) * (oh - ol) / (hi - lo);
  endfunction
  task automatic chk(string nm, int exp, logic [15:0] got);
    cmp_count++;
    if (got !== 16'(exp)) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, 16'(exp), got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, int d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in) pen <= 1;
    // Only the cycle ceiling ends a wait, so a missing answer can never slip by unnoticed.
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clock_in);
  endtask
  // Both channels sample together; outputs settle within four edges, six are given.
  task automatic smp(int x1, int y1, int x2, int y2);
    g <= 1;
    a1 <= 16'(x1);
    b1 <= 16'(y1);
    a2 <= 16'(x2);
    b2 <= 16'(y2);
    @(posedge clock_in) g <= 0;
    repeat (5) @(posedge clock_in);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    reset_in <= 0;
    @(posedge clock_in);
    apb(0, A_IN1_HI, 0);
    chk("in1_hi", 10000, rd[15:0]);
    apb(1, 8'h5c, 1);
    chk("slverr", 1, {15'h0, er});
    apb(1, A_SEL, 32'h2591);
    for (int i = 0; i < 12; i++) begin
      lf = rnd(lf);
      x = (i < 2) ? i * 10000 : lf % 12000;
      lf = rnd(lf);
      y = lf % 12000;
      smp(x, 0, y, 0);
      chk("speed", scl(x, 0, 10000, 0, 6000), o[0]);
      chk("torque", scl(x, 0, 10000, 0, 20000), o[2]);
      chk("clim", scl(y, 0, 10000, 0, 10000), o[3]);
      chk("dc_hold", scl(x, 0, 10000, 0, 10000), o[4]);
      chk("setpoint", scl(x, 0, 10000, 0, 10000), o[5]);
      chk("feedback", scl(y, 0, 10000, 0, 10000), o[6]);
    end
    apb(1, A_SEL, 32'h2599);
    for (int j = 0; j < 3; j++) begin
      smp(5000, 0, j * 5000, 0);
      chk("trim", (j - 1) * 1000, o[1]);
      chk("trimmed", 3000 + 300 * (j - 1), o[0]);
    end
    apb(1, A_SEL, 32'h2591);
    apb(1, A_CFG, 3);
    apb(1, A_IN1_LO, 4000);
    apb(1, A_IN1_HI, 20000);
    smp(1000, 12000, 0, 8000);
    chk("speed_ma", 3000, o[0]);
    chk("feedback_ma", 8000, o[6]);
    smp(1000, 4000, 0, 0);
    chk("speed_4ma", 0, o[0]);
    apb(1, A_SPD_LO, 6000);
    apb(1, A_SPD_HI, 0);
    smp(1000, 8000, 0, 0);
    chk("speed_inv", 4500, o[0]);
    apb(1, A_CFG, 0);
    apb(1, A_IN1_LO, 0);
    apb(1, A_IN1_HI, 5000);
    apb(1, A_SPD_LO, 0);
    apb(1, A_SPD_HI, 6000);
    smp(2500, 0, 0, 0);
    chk("speed_5v", 3000, o[0]);
    apb(1, A_MIN_SPD, 1500);
    apb(1, A_MAX_FRQ, 4500);
    smp(1000, 0, 0, 0);
    chk("speed_min", 1500, o[0]);
    apb(0, A_VIEW1, 0);
    chk("view1", 2100, rd[15:0]);
    smp(6000, 0, 0, 0);
    chk("speed_max", 4500, o[0]);
    finish_test();
  end
endmodule
